// file: hw/cwf_pkg.sv
/*
  constants, field layout and state types of the comparator window filter.
  assumes a single 100 MHz bus clock and an axi4-lite register port.
*/
package cwf_pkg;

  localparam logic [3:0] OFS_CTRL0  = 4'h0;
  localparam logic [3:0] OFS_CTRL1  = 4'h4;
  localparam logic [3:0] OFS_PERIOD = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  localparam int CTRL1_ON  = 0;
  localparam int CTRL1_INV = 1;
  localparam int CTRL1_WE  = 2;
  localparam int CTRL1_SE  = 3;

  localparam int STS_OUT  = 0;
  localparam int STS_RISE = 1;
  localparam int STS_FALL = 2;
  localparam int STS_RIE  = 3;
  localparam int STS_FIE  = 4;

  localparam logic [7:0] RST_COUNT  = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    MODE_OFF, MODE_CONT, MODE_SAMPLED, MODE_WIN, MODE_WIN_FILT
  } cwf_mode_t;

  typedef struct packed {
    logic [2:0] chain;
    logic       clean;
  } cwf_sync_t;

  typedef struct packed {
    cwf_sync_t  cmp;
    cwf_sync_t  win;
    cwf_sync_t  smp;
    logic       smp_prev;
    logic [7:0] agree_count;
    logic [7:0] sample_period;
    logic       comparator_on;
    logic       polarity_flip;
    logic       window_enable;
    logic       ext_sample_on;
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic       rise_flag;
    logic       fall_flag;
    logic       win_latch;
    logic [7:0] div_cnt;
    logic [7:0] agree_run;
    logic       filt_out;
    logic       status_out;
    logic       aw_have;
    logic       w_have;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cwf_state_t;

endpackage : cwf_pkg

// file: hw/cwf_top.sv
/*
  comparator window filter: window latch, resampler, agreement filter,
  edge flags and an axi4-lite register slave.
  assumes comparator, window and sample inputs are asynchronous pins.
*/
`timescale 1ns/1ns
`default_nettype none
module cwf_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        cmp_analog_in,
  input  wire logic        window_in,
  input  wire logic        sample_in,
  output logic             comparator_raw_output,
  output logic             window_stage_output,
  output logic             filtered_output,
  output logic             irq,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  cwf_pkg::cwf_state_t q;
  cwf_pkg::cwf_state_t d;
  cwf_pkg::cwf_mode_t  mode;
  logic                cmp_pol;
  logic                filt_off;
  logic                tick;
  logic                sample_val;
  logic                cmp_sync_pol;
  logic                status_src;
  logic                do_write;
  logic [3:0]          rd_idx;

  function automatic cwf_pkg::cwf_sync_t sync_step(
    input cwf_pkg::cwf_sync_t s,
    input logic               pin
  );
    cwf_pkg::cwf_sync_t n;
    // stage zero feeds only stage one
    n.chain = {s.chain[1:0], pin};
    // a change counts once the second and third stages agree
    n.clean = (s.chain[1] == s.chain[2]) ? s.chain[2] : s.clean;
    return n;
  endfunction : sync_step

  // raw comparator is forced low while switched off
  assign comparator_raw_output = q.comparator_on & cmp_analog_in;
  assign cmp_pol = comparator_raw_output ^ q.polarity_flip;

  // filter is bypassed when the sample pin is off and either the agreement count or the period is zero
  assign filt_off = !q.ext_sample_on &&
                    (q.agree_count == 8'h00 || q.sample_period == 8'h00);

  always_comb begin
    if (!q.comparator_on) begin
      mode = cwf_pkg::MODE_OFF;
    end else if (q.window_enable) begin
      mode = filt_off ? cwf_pkg::MODE_WIN : cwf_pkg::MODE_WIN_FILT;
    end else begin
      mode = filt_off ? cwf_pkg::MODE_CONT : cwf_pkg::MODE_SAMPLED;
    end
  end

  always_comb begin
    case (mode)
      cwf_pkg::MODE_OFF: begin
        window_stage_output = 1'b0;
        filtered_output     = 1'b0;
      end
      cwf_pkg::MODE_CONT: begin
        // unclocked path so a fault reaches its target immediately
        window_stage_output = cmp_pol;
        filtered_output     = cmp_pol;
      end
      cwf_pkg::MODE_SAMPLED: begin
        window_stage_output = cmp_pol;
        filtered_output     = q.filt_out;
      end
      cwf_pkg::MODE_WIN: begin
        window_stage_output = q.win_latch;
        filtered_output     = q.win_latch;
      end
      cwf_pkg::MODE_WIN_FILT: begin
        window_stage_output = q.win_latch;
        filtered_output     = q.filt_out;
      end
      default: begin
        window_stage_output = 1'b0;
        filtered_output     = 1'b0;
      end
    endcase
  end

  // clocked paths use the synchronised comparator; the window stage in
  // windowed modes is the latch, otherwise the synchronised level
  // inverted like the unclocked window stage so both paths agree on level
  assign cmp_sync_pol = (q.cmp.clean & q.comparator_on) ^ q.polarity_flip;
  assign sample_val   = q.window_enable ? q.win_latch : cmp_sync_pol;
  // filter clock: sample pin edge or bus clock divided by sample_period
  assign tick = q.ext_sample_on ? (q.smp.clean & !q.smp_prev)
                                : (q.div_cnt + 8'h01 >= q.sample_period);
  assign status_src = (mode == cwf_pkg::MODE_CONT) ? (q.cmp.clean ^
                      q.polarity_flip) : filtered_output;

  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign irq = (q.rise_flag & q.rise_irq_enable) |
               (q.fall_flag & q.fall_irq_enable);
  assign do_write = q.aw_have && q.w_have && !q.bvalid;
  assign rd_idx   = s_axi_araddr[3:0];

  always_comb begin
    d = q;
    d.cmp = sync_step(q.cmp, cmp_analog_in);
    d.win = sync_step(q.win, window_in);
    d.smp = sync_step(q.smp, sample_in);
    d.smp_prev = q.smp.clean;

    // window latch follows comparator only while window is high
    if (q.window_enable && q.win.clean) begin
      d.win_latch = cmp_sync_pol;
    end

    if (filt_off || !q.comparator_on) begin
      // known filter state while sampling is switched off
      d.div_cnt   = 8'h00;
      d.agree_run = 8'h00;
      d.filt_out  = 1'b0;
    end else begin
      if (!q.ext_sample_on) begin
        d.div_cnt = tick ? 8'h00 : q.div_cnt + 8'h01;
      end
      if (tick) begin
        if (q.agree_count <= 8'h01) begin
          d.filt_out = sample_val;
        end else if (sample_val == q.filt_out) begin
          d.agree_run = 8'h00;
        end else if (q.agree_run + 8'h02 > q.agree_count) begin
          d.filt_out  = sample_val;
          d.agree_run = 8'h00;
        end else begin
          d.agree_run = q.agree_run + 8'h01;
        end
      end
    end

    d.status_out = status_src;

    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (do_write) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = cwf_pkg::RESP_OKAY;
      case (q.aw_addr)
        cwf_pkg::OFS_CTRL0: begin
          if (q.w_strb[0]) d.agree_count = q.w_data[7:0];
        end
        cwf_pkg::OFS_CTRL1: begin
          if (q.w_strb[0]) begin
            d.comparator_on = q.w_data[cwf_pkg::CTRL1_ON];
            d.polarity_flip = q.w_data[cwf_pkg::CTRL1_INV];
            d.window_enable = q.w_data[cwf_pkg::CTRL1_WE];
            d.ext_sample_on = q.w_data[cwf_pkg::CTRL1_SE];
          end
        end
        cwf_pkg::OFS_PERIOD: begin
          if (q.w_strb[0]) d.sample_period = q.w_data[7:0];
        end
        cwf_pkg::OFS_STATUS: begin
          if (q.w_strb[0]) begin
            if (q.w_data[cwf_pkg::STS_RISE]) d.rise_flag = 1'b0;
            if (q.w_data[cwf_pkg::STS_FALL]) d.fall_flag = 1'b0;
            d.rise_irq_enable = q.w_data[cwf_pkg::STS_RIE];
            d.fall_irq_enable = q.w_data[cwf_pkg::STS_FIE];
          end
        end
        default: d.bresp = cwf_pkg::RESP_SLVERR;
      endcase
    end

    // edges set after the clear so a coinciding event is kept
    if (status_src && !q.status_out) d.rise_flag = 1'b1;
    if (!status_src && q.status_out) d.fall_flag = 1'b1;

    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = cwf_pkg::RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      case (rd_idx)
        cwf_pkg::OFS_CTRL0:  d.rdata[7:0] = q.agree_count;
        cwf_pkg::OFS_PERIOD: d.rdata[7:0] = q.sample_period;
        cwf_pkg::OFS_CTRL1: begin
          d.rdata[cwf_pkg::CTRL1_ON]  = q.comparator_on;
          d.rdata[cwf_pkg::CTRL1_INV] = q.polarity_flip;
          d.rdata[cwf_pkg::CTRL1_WE]  = q.window_enable;
          d.rdata[cwf_pkg::CTRL1_SE]  = q.ext_sample_on;
        end
        cwf_pkg::OFS_STATUS: begin
          d.rdata[cwf_pkg::STS_OUT]  = q.status_out;
          d.rdata[cwf_pkg::STS_RISE] = q.rise_flag;
          d.rdata[cwf_pkg::STS_FALL] = q.fall_flag;
          d.rdata[cwf_pkg::STS_RIE]  = q.rise_irq_enable;
          d.rdata[cwf_pkg::STS_FIE]  = q.fall_irq_enable;
        end
        default: d.rresp = cwf_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.agree_count   <= cwf_pkg::RST_COUNT;
      q.sample_period <= cwf_pkg::RST_PERIOD;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // checks run on the bus clock and stay quiet while reset is held
  AST_OFF_ZERO: assert property (
    !q.comparator_on |-> !comparator_raw_output && !filtered_output
  ) else $error("output not zero while disabled");
  AST_CONT_PASS: assert property (
    mode == cwf_pkg::MODE_CONT |-> filtered_output == cmp_pol
  ) else $error("continuous output does not follow comparator");
  AST_WIN_HOLD: assert property (
    q.window_enable && !q.win.clean && $stable(q.window_enable)
    |=> $stable(q.win_latch)
  ) else $error("window latch moved while window low");
  AST_WIN_LATCH: assert property (
    q.window_enable && q.win.clean && q.comparator_on
    |=> q.win_latch == $past(cmp_sync_pol)
  ) else $error("window latch missed comparator");
  AST_FILT_RESET: assert property (
    filt_off |=> !q.filt_out && q.agree_run == 8'h00
  ) else $error("filter not reset while bypassed");
  AST_SH: assert property (
    tick && !filt_off && q.comparator_on && q.agree_count == 8'h01
    |=> q.filt_out == $past(sample_val)
  ) else $error("sample-and-hold missed sample");
  AST_SAMPLED_POL: assert property (
    mode == cwf_pkg::MODE_SAMPLED && tick && q.agree_count == 8'h01
    |=> q.filt_out == $past(cmp_sync_pol)
  ) else $error("sampled filter took wrong comparator level");
  AST_AGREE: assert property (
    q.agree_count > 8'h01 && !filt_off && q.comparator_on &&
    !(tick && q.agree_run + 8'h02 > q.agree_count) |=> $stable(q.filt_out)
  ) else $error("filter changed before enough agreeing samples");
  AST_DIV: assert property (
    !q.ext_sample_on && !filt_off && q.comparator_on && tick
    |=> q.div_cnt == 8'h00
  ) else $error("divider not restarted after sample");
  AST_RISE: assert property (
    status_src && !q.status_out |=> q.rise_flag
  ) else $error("rising edge lost");
  AST_FALL: assert property (
    !status_src && q.status_out |=> q.fall_flag
  ) else $error("falling edge lost");
  AST_STATUS: assert property (
    1'b1 |=> q.status_out == $past(status_src)
  ) else $error("status copy lags more than one clock");

endmodule : cwf_top
`default_nettype wire

// file: tb/comparator_window_filter_tb_top.sv
/*
  bench: axi4-lite register tasks and mode-by-mode pin scenarios.
  assumes cwf_top and the pin model share the bench's signal names.
*/
`timescale 1ns/1ns
`default_nettype none
module comparator_window_filter_tb_top;
  localparam logic [7:0] B_ON   = 8'h01 << cwf_pkg::CTRL1_ON;
  localparam logic [7:0] B_INV  = 8'h01 << cwf_pkg::CTRL1_INV;
  localparam logic [7:0] B_WE   = 8'h01 << cwf_pkg::CTRL1_WE;
  localparam logic [7:0] B_SE   = 8'h01 << cwf_pkg::CTRL1_SE;
  localparam logic [7:0] S_OUT  = 8'h01 << cwf_pkg::STS_OUT;
  localparam logic [7:0] S_RISE = 8'h01 << cwf_pkg::STS_RISE;
  localparam logic [7:0] S_FALL = 8'h01 << cwf_pkg::STS_FALL;
  localparam logic [7:0] S_RIE  = 8'h01 << cwf_pkg::STS_RIE;
  localparam logic [7:0] S_FIE  = 8'h01 << cwf_pkg::STS_FIE;
  logic        clock, rst_n, irq;
  logic        cmp_analog_in, window_in, sample_in;
  logic        comparator_raw_output, window_stage_output, filtered_output;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;

  cwf_top       i_cwf_top (.*);
  cwf_pin_model i_cwf_pin_model (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // whole run is about four hundred clocks; this only catches a hang
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic pick(input int k);
    return k == 0 ? filtered_output : window_stage_output;
  endfunction : pick

  // an edge passes first so no strobe is dropped and raised in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    s_axi_awaddr  <= {28'h0000000, a};
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, cwf_pkg::RESP_OKAY});
  endtask : wr

  task automatic axr(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr  <= {28'h0000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic rd(input string what, input logic [3:0] a,
                    input logic [7:0] e);
    axr(a);
    chk(what, rdat, {24'h000000, e});
  endtask : rd

  task automatic wt(input string what, input int k, input logic e,
                    input int lim);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pick(k) !== e && n < lim);
    chk(what, {31'h0, pick(k)}, {31'h0, e});
  endtask : wt

  task automatic hold(input string what, input int k, input logic e,
                      input int len);
    repeat (len) begin
      @(posedge clock);
      chk(what, {31'h0, pick(k)}, {31'h0, e});
    end
  endtask : hold

  task automatic cfg(input logic [7:0] cnt, input logic [7:0] c1,
                     input logic [7:0] per);
    wr(cwf_pkg::OFS_CTRL1, B_ON);
    wr(cwf_pkg::OFS_CTRL0, 8'h00);
    wr(cwf_pkg::OFS_PERIOD, per);
    wr(cwf_pkg::OFS_CTRL1, c1);
    wr(cwf_pkg::OFS_CTRL0, cnt);
  endtask : cfg

  initial begin
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd("ctrl0", cwf_pkg::OFS_CTRL0, cwf_pkg::RST_COUNT);
    rd("period", cwf_pkg::OFS_PERIOD, cwf_pkg::RST_PERIOD);
    rd("ctrl1", cwf_pkg::OFS_CTRL1, 8'h00);
    axr(4'h2);
    chk("unmapped", {30'h0, resp}, {30'h0, cwf_pkg::RESP_SLVERR});
    i_cwf_pin_model.set_pins(1'b1, 1'b0);
    repeat (8) @(posedge clock);
    chk("raw", {31'h0, comparator_raw_output}, 32'h0);
    wr(cwf_pkg::OFS_CTRL1, B_ON);
    @(posedge clock);
    chk("raw", {31'h0, comparator_raw_output}, 32'h1);
    hold("filt", 0, 1'b1, 1);
    hold("win", 1, 1'b1, 1);
    repeat (6) @(posedge clock);
    rd("status", cwf_pkg::OFS_STATUS, S_OUT | S_RISE);
    wr(cwf_pkg::OFS_STATUS, S_RISE | S_RIE);
    rd("status", cwf_pkg::OFS_STATUS, S_OUT | S_RIE);
    i_cwf_pin_model.set_pins(1'b0, 1'b0);
    hold("filt", 0, 1'b0, 1);
    repeat (8) @(posedge clock);
    rd("status", cwf_pkg::OFS_STATUS, S_FALL | S_RIE);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(cwf_pkg::OFS_STATUS, S_RIE | S_FIE);
    @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(cwf_pkg::OFS_STATUS, S_FALL | S_RIE | S_FIE);
    @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(cwf_pkg::OFS_CTRL1, B_ON | B_INV);
    hold("filt", 0, 1'b1, 1);
    wr(cwf_pkg::OFS_STATUS, 8'h00);
    cfg(8'h00, B_ON | B_WE, 8'h00);
    i_cwf_pin_model.set_pins(1'b1, 1'b1);
    wt("win", 1, 1'b1, 12);
    i_cwf_pin_model.set_pins(1'b1, 1'b0);
    repeat (6) @(posedge clock);
    i_cwf_pin_model.set_pins(1'b0, 1'b0);
    hold("win", 1, 1'b1, 12);
    i_cwf_pin_model.set_pins(1'b0, 1'b1);
    wt("win", 1, 1'b0, 12);
    cfg(8'h01, B_ON, 8'h04);
    i_cwf_pin_model.set_pins(1'b1, 1'b0);
    wt("filt", 0, 1'b1, 30);
    i_cwf_pin_model.set_pins(1'b0, 1'b0);
    wt("filt", 0, 1'b0, 30);
    i_cwf_pin_model.set_pins(1'b1, 1'b0);
    cfg(8'h03, B_ON, 8'h02);
    hold("filt", 0, 1'b0, 1);
    wt("filt", 0, 1'b1, 40);
    chk("agree wait", {31'h0, n >= 4}, 32'h1);
    cfg(8'h02, B_ON | B_SE, 8'h00);
    hold("filt", 0, 1'b0, 16);
    i_cwf_pin_model.pulse_sample();
    hold("filt", 0, 1'b0, 1);
    i_cwf_pin_model.pulse_sample();
    wt("filt", 0, 1'b1, 10);
    cfg(8'h01, B_ON | B_WE, 8'h03);
    i_cwf_pin_model.set_pins(1'b1, 1'b1);
    wt("filt", 0, 1'b1, 40);
    i_cwf_pin_model.set_pins(1'b1, 1'b0);
    repeat (6) @(posedge clock);
    i_cwf_pin_model.set_pins(1'b0, 1'b0);
    hold("filt", 0, 1'b1, 20);
    cfg(8'h03, B_ON | B_WE, 8'h03);
    hold("filt", 0, 1'b0, 1);
    i_cwf_pin_model.set_pins(1'b1, 1'b1);
    wt("filt", 0, 1'b1, 80);
    chk("agree wait", {31'h0, n >= 7}, 32'h1);
    cfg(8'h01, B_ON | B_INV, 8'h02);
    i_cwf_pin_model.set_pins(1'b0, 1'b0);
    hold("win", 1, 1'b1, 1);
    wt("filt", 0, 1'b1, 30);
    cfg(8'h00, B_ON | B_INV | B_WE, 8'h00);
    i_cwf_pin_model.set_pins(1'b1, 1'b1);
    wt("win", 1, 1'b0, 12);
    summarize();
  end
endmodule : comparator_window_filter_tb_top
`default_nettype wire

// file: tb/cwf_pin_model.sv
/*
  pin-side model: comparator result, window and external sample pins.
  assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cwf_pin_model (
  input  wire logic clock,
  output logic      cmp_analog_in,
  output logic      window_in,
  output logic      sample_in
);
  initial begin
    cmp_analog_in = 1'b0;
    window_in     = 1'b0;
    sample_in     = 1'b0;
  end

  task automatic set_pins(input logic c, input logic w);
    cmp_analog_in <= c;
    window_in     <= w;
  endtask : set_pins

  // held four clocks so the pulse survives the pin synchroniser
  task automatic pulse_sample();
    sample_in <= 1'b1;
    repeat (4) @(posedge clock);
    sample_in <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse_sample
endmodule : cwf_pin_model
`default_nettype wire
